// ==== verilog/sics_pkg.sv ====
// Constants shared by the serial control and status block and its divider.
// Assumes an APB master on pclk; offsets are byte addresses of 32-bit words.
package sics_pkg;
  localparam logic [7:0] SICS_OFS_CTL_MAIN = 8'h00;
  localparam logic [7:0] SICS_OFS_CTL_IRQ = 8'h04;
  localparam logic [7:0] SICS_OFS_STATUS = 8'h08;
  localparam logic [7:0] SICS_OFS_DATA = 8'h0C;
  localparam logic [7:0] SICS_OFS_AUDIO = 8'h1C;
  // Main control fields
  localparam int SICS_C0_BIDIR = 15;
  localparam int SICS_C0_BOE = 14;
  localparam int SICS_C0_CKEN = 13;
  localparam int SICS_C0_CKNX = 12;
  localparam int SICS_C0_FW16 = 11;
  localparam int SICS_C0_RXO = 10;
  localparam int SICS_C0_SSEN = 9;
  localparam int SICS_C0_SSLV = 8;
  localparam int SICS_C0_EN = 6;
  localparam int SICS_C0_DIV = 3;
  localparam int SICS_C0_MST = 2;
  localparam int SICS_C0_CPOL = 1;
  localparam int SICS_C0_CPHA = 0;
  // Interrupt and DMA control fields
  localparam int SICS_C1_TXIE = 7;
  localparam int SICS_C1_RXIE = 6;
  localparam int SICS_C1_ERR_IE = 5;
  localparam int SICS_C1_ALT = 4;
  localparam int SICS_C1_DRV = 2;
  localparam int SICS_C1_TDMA = 1;
  localparam int SICS_C1_RDMA = 0;
  localparam logic [7:0] SICS_C1_MASK = 8'hF7;
  // Audio control fields
  localparam int SICS_AU_SEL = 11;
  localparam int SICS_AU_EN = 10;
  localparam int SICS_AU_OPM = 8;
  localparam int SICS_AU_STD = 4;
  localparam int SICS_AU_CPOL = 3;
  localparam logic [11:0] SICS_AU_MASK = 12'hFBF;
  localparam logic [1:0] SICS_STD_PCM = 2'h3;
  // Status fields
  localparam int SICS_ST_CRC = 4;
  localparam logic [31:0] SICS_STAT_RESET = 32'h0000_0002;
  // Frame lengths and divider
  localparam logic [4:0] SICS_BITS16 = 5'h10;
  localparam logic [4:0] SICS_BITS8 = 5'h08;
  localparam int SICS_DIV_W = 7;
endpackage : sics_pkg

// ==== verilog/sics_clkdiv.sv ====
// Half-period tick generator for the master serial clock.
// Assumes run drops whenever no master frame is in progress.
`timescale 1ns/100ps
`default_nettype none
module sics_clkdiv
  import sics_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [SICS_DIV_W-1:0] cnt_q;
  logic [SICS_DIV_W-1:0] lim;

  // Toggle every 2^sel cycles: full period pclk/2 .. pclk/256
  assign lim = SICS_DIV_W'((8'h01 << sel) - 8'h01);
  assign tick = run && (cnt_q == lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!run || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : sics_clkdiv
`default_nettype wire

// ==== verilog/sics_top.sv ====
// Serial port control, status, buffers and shifter, APB register slave.
// Assumes pins synchronous to pclk; checksums come from an outside unit.
`timescale 1ns/100ps
`default_nettype none
module sics_top
  import sics_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic nss_i,
  output logic nss_o,
  output logic nss_oe,
  input wire logic ws_i,
  output logic ws_o,
  output logic ws_oe,
  input wire logic [15:0] tx_checksum_i,
  input wire logic [15:0] rx_checksum_i,
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  logic [15:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [11:0] aud_q;
  logic [15:0] tx_buf_q, rx_buf_q, txs_q, rxs_q;
  logic tx_full_q, rx_full_q, ld_q, act_q, sck_q;
  logic [4:0] cnt_q;
  logic sck_prev_q, sync_prev_q, te_prev_q, rf_prev_q;
  logic und_q, ovr_q, cfg_q, crc_q, frame_sync_error_q, ch_q, par_q;
  logic ovr_arm_q, cfg_arm_q, crc_rx_q;
  logic [31:0] prdata_q;

  logic acc, wr, rd, hit;
  logic wr_c0, wr_st, rd_st, acc_st, wr_dat, rd_dat;
  logic aud, en, mst, txm, rxm, cpol, cpha, w16, int_sel, slv_on;
  logic tick, ev, lead, smp, done, pend, crc_go, st, load, take_buf;
  logic [4:0] bits, cnt_n;
  logic din, dout, drv, out_mosi, sync_now, cfg_cond, te, rise;
  logic [15:0] rx_word, rx_word_m;
  logic [31:0] rdmux;

  // APB decode; every register answers with no wait state
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit = (paddr == SICS_OFS_CTL_MAIN) || (paddr == SICS_OFS_CTL_IRQ) ||
               (paddr == SICS_OFS_STATUS) || (paddr == SICS_OFS_DATA) ||
               (paddr == SICS_OFS_AUDIO);
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign wr_c0 = wr && (paddr == SICS_OFS_CTL_MAIN);
  assign acc_st = acc && (paddr == SICS_OFS_STATUS);
  assign wr_st = acc_st && pwrite;
  assign rd_st = acc_st && !pwrite;
  assign wr_dat = wr && (paddr == SICS_OFS_DATA);
  assign rd_dat = rd && (paddr == SICS_OFS_DATA);

  // Mode decode
  assign aud = aud_q[SICS_AU_SEL];
  assign en = aud ? aud_q[SICS_AU_EN] : ctl0_q[SICS_C0_EN];
  assign mst = aud ? aud_q[SICS_AU_OPM+1] : ctl0_q[SICS_C0_MST];
  assign txm = aud ? !aud_q[SICS_AU_OPM] :
               (ctl0_q[SICS_C0_BIDIR] ? ctl0_q[SICS_C0_BOE] : !ctl0_q[SICS_C0_RXO]);
  assign rxm = aud ? aud_q[SICS_AU_OPM] :
               (ctl0_q[SICS_C0_BIDIR] ? !ctl0_q[SICS_C0_BOE] : 1'b1);
  assign cpol = aud ? aud_q[SICS_AU_CPOL] : ctl0_q[SICS_C0_CPOL];
  assign cpha = aud ? 1'b0 : ctl0_q[SICS_C0_CPHA];
  assign w16 = aud || ctl0_q[SICS_C0_FW16];
  assign bits = w16 ? SICS_BITS16 : SICS_BITS8;
  // Frame sync mode always takes the pin
  assign int_sel = (ctl0_q[SICS_C0_SSEN] && !ctl1_q[SICS_C1_ALT]) ?
                   ctl0_q[SICS_C0_SSLV] : nss_i;
  assign slv_on = en && !mst && (aud || !int_sel);
  assign cfg_cond = !aud && ctl0_q[SICS_C0_MST] && !int_sel;

  sics_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(act_q),
    .sel(ctl0_q[SICS_C0_DIV+2:SICS_C0_DIV]),
    .tick(tick)
  );

  // Serial clock edges: own divider in master, pin in slave
  assign ev = mst ? (act_q && tick) : (slv_on && (sck_i != sck_prev_q));
  assign lead = (mst ? !sck_q : sck_i) != cpol;
  assign smp = lead ^ cpha;
  assign cnt_n = cnt_q + {4'h0, smp};
  // Every word ends on a trailing edge, so the clock is back at idle
  assign done = ev && !lead && (cnt_n == bits);
  assign out_mosi = mst || aud;
  assign din = (out_mosi ^ ctl0_q[SICS_C0_BIDIR]) ? miso_i : mosi_i;
  assign rx_word = smp ? {rxs_q[14:0], din} : rxs_q;
  assign rx_word_m = w16 ? rx_word : {8'h00, rx_word[7:0]};
  assign dout = w16 ? txs_q[15] : txs_q[7];

  // Checksum word goes out after the last data word
  assign crc_go = !aud && ctl0_q[SICS_C0_CKEN] && ctl0_q[SICS_C0_CKNX];
  assign pend = txm && (crc_go || tx_full_q);
  assign st = en && mst && !act_q && !cfg_q && (pend || !txm);
  assign load = (st && pend) || (done && pend) ||
                (en && !mst && txm && !ld_q && (cnt_q == 5'h00) && pend);
  assign take_buf = load && !crc_go;

  // Pins
  assign drv = en && txm && (mst || slv_on);
  assign sck_o = sck_q;
  assign sck_oe = en && mst;
  assign mosi_o = dout;
  assign mosi_oe = drv && out_mosi;
  assign miso_o = dout;
  assign miso_oe = drv && !out_mosi;
  assign nss_o = 1'b0;
  assign nss_oe = !aud && ctl1_q[SICS_C1_DRV] && ctl0_q[SICS_C0_MST] &&
                  ctl0_q[SICS_C0_EN];
  assign ws_o = txm ? !par_q : par_q;
  assign ws_oe = en && aud && mst;

  // Flags out
  assign te = !tx_full_q;
  assign irq = (te && ctl1_q[SICS_C1_TXIE]) ||
               (rx_full_q && ctl1_q[SICS_C1_RXIE]) ||
               (ctl1_q[SICS_C1_ERR_IE] && (crc_q || cfg_q || ovr_q || und_q || frame_sync_error_q));
  assign tx_dma_req = te && ctl1_q[SICS_C1_TDMA];
  assign rx_dma_req = rx_full_q && ctl1_q[SICS_C1_RDMA];

  assign sync_now = aud ? ws_i : nss_i;
  assign rise = txm ? (te && !te_prev_q) : (rx_full_q && !rf_prev_q);

  always_comb begin
    rdmux = 32'h0000_0000;
    unique case (paddr)
      SICS_OFS_CTL_MAIN: rdmux = {16'h0000, ctl0_q};
      SICS_OFS_CTL_IRQ: rdmux = {24'h000000, ctl1_q};
      SICS_OFS_STATUS: rdmux = {23'h000000, frame_sync_error_q, act_q, ovr_q, cfg_q, crc_q,
                                und_q, ch_q, te, rx_full_q};
      SICS_OFS_DATA: rdmux = {16'h0000, rx_buf_q};
      SICS_OFS_AUDIO: rdmux = {20'h00000, aud_q};
      default: rdmux = 32'h0000_0000;
    endcase
  end

  // Read data held from the setup cycle through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= rdmux;
    end
  end
  assign prdata = prdata_q;

  // Control registers; audio select is left to software discipline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_q <= 16'h0000;
    end else if (wr_c0) begin
      ctl0_q <= pwdata[15:0];
    end else if (load && crc_go) begin
      ctl0_q[SICS_C0_CKNX] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_q <= 8'h00;
      aud_q <= 12'h000;
    end else if (wr && (paddr == SICS_OFS_CTL_IRQ)) begin
      ctl1_q <= pwdata[7:0] & SICS_C1_MASK;
    end else if (wr && (paddr == SICS_OFS_AUDIO)) begin
      aud_q <= pwdata[11:0] & SICS_AU_MASK;
    end
  end

  // Transmit buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_q <= 16'h0000;
      tx_full_q <= 1'b0;
    end else if (wr_dat) begin
      tx_buf_q <= w16 ? pwdata[15:0] : {8'h00, pwdata[7:0]};
      tx_full_q <= 1'b1;
    end else if (take_buf) begin
      tx_full_q <= 1'b0;
    end
  end

  // Receive buffer; a read in the same cycle frees it for the new word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= 16'h0000;
      rx_full_q <= 1'b0;
    end else if (done && rxm && (!rx_full_q || rd_dat)) begin
      rx_buf_q <= rx_word_m;
      rx_full_q <= 1'b1;
    end else if (rd_dat) begin
      rx_full_q <= 1'b0;
    end
  end

  // Shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txs_q <= 16'h0000;
      rxs_q <= 16'h0000;
      cnt_q <= 5'h00;
    end else begin
      if (load) begin
        txs_q <= crc_go ? tx_checksum_i : tx_buf_q;
      end else if (ev && !smp && (cnt_q != 5'h00)) begin
        txs_q <= {txs_q[14:0], 1'b0};
      end
      if (ev && smp) begin
        rxs_q <= {rxs_q[14:0], din};
      end
      if (!(mst ? en : slv_on) || done) begin
        cnt_q <= 5'h00;
      end else if (ev) begin
        cnt_q <= cnt_n;
      end
    end
  end

  // Master frame control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
      sck_q <= 1'b0;
      ld_q <= 1'b0;
    end else begin
      if (!en || !mst) begin
        act_q <= 1'b0;
      end else if (st) begin
        act_q <= 1'b1;
      end else if (done && !(pend || !txm)) begin
        act_q <= 1'b0;
      end
      if (!act_q) begin
        sck_q <= cpol;
      end else if (tick) begin
        sck_q <= !sck_q;
      end
      if (!en) begin
        ld_q <= 1'b0;
      end else if (load) begin
        ld_q <= 1'b1;
      end else if (done) begin
        ld_q <= 1'b0;
      end
    end
  end

  // Edge history of pins and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_q <= 1'b0;
      sync_prev_q <= 1'b0;
      te_prev_q <= 1'b1;
      rf_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_i;
      sync_prev_q <= sync_now;
      te_prev_q <= te;
      rf_prev_q <= rx_full_q;
    end
  end

  // Channel side: word parity in master, sync line in slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_q <= 1'b0;
      ch_q <= 1'b0;
    end else begin
      if (!en) begin
        par_q <= 1'b0;
      end else if (mst && ((txm && take_buf) || (!txm && done))) begin
        par_q <= !par_q;
      end
      if (aud && (aud_q[SICS_AU_STD+1:SICS_AU_STD] != SICS_STD_PCM) && rise) begin
        ch_q <= mst ? (txm ? par_q : !par_q) : ws_i;
      end
    end
  end

  // Error flags; in every case a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      und_q <= 1'b0;
      frame_sync_error_q <= 1'b0;
    end else begin
      if (!mst && txm && ev && lead && (cnt_q == 5'h00) && !ld_q) begin
        und_q <= 1'b1;
      end else if (rd_st) begin
        und_q <= 1'b0;
      end
      // Only a slave follows the frame sync, so only it can see it misplaced
      if (slv_on && (aud || ctl1_q[SICS_C1_ALT]) && (sync_now != sync_prev_q) &&
          (cnt_q != 5'h00)) begin
        frame_sync_error_q <= 1'b1;
      end else if (rd_st) begin
        frame_sync_error_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_q <= 1'b0;
      ovr_arm_q <= 1'b0;
    end else begin
      if (done && rxm && rx_full_q && !rd_dat) begin
        ovr_q <= 1'b1;
      end else if (rd_st && ovr_arm_q) begin
        ovr_q <= 1'b0;
      end
      if (rd_dat) begin
        ovr_arm_q <= 1'b1;
      end else if (rd_st) begin
        ovr_arm_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 1'b0;
      cfg_arm_q <= 1'b0;
    end else begin
      if (cfg_cond) begin
        cfg_q <= 1'b1;
      end else if (wr_c0 && cfg_arm_q) begin
        cfg_q <= 1'b0;
      end
      if (acc_st) begin
        cfg_arm_q <= 1'b1;
      end else if (wr_c0) begin
        cfg_arm_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= 1'b0;
      crc_rx_q <= 1'b0;
    end else begin
      if (done && crc_rx_q && !aud && (rx_word_m != rx_checksum_i)) begin
        crc_q <= 1'b1;
      end else if (wr_st && !pwdata[SICS_ST_CRC]) begin
        crc_q <= 1'b0;
      end
      if (load && crc_go) begin
        crc_rx_q <= 1'b1;
      end else if (done || !en) begin
        crc_rx_q <= 1'b0;
      end
    end
  end
endmodule : sics_top
`default_nettype wire

// ==== test/sics_asserts.sv ====
// Port checker for the serial control block, bound to its top.
// Assumes control bits mirror APB writes; audio mode only with select drive off.
`timescale 1ns/100ps
`default_nettype none
module sics_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic nss_oe,
  input wire logic irq,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req
);
  logic [15:0] c0_q;
  logic [7:0] c1_q;
  logic sck_q;
  logic [8:0] gap_q;
  logic acc;
  assign acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_q <= 16'h0000;
      c1_q <= 8'h00;
    end else if (acc && pwrite) begin
      if (paddr == 8'h00) c0_q <= pwdata[15:0];
      if (paddr == 8'h04) c1_q <= pwdata[7:0];
    end
  end
  // Saturates below all ones so the compare cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      gap_q <= 9'h1FE;
    end else begin
      sck_q <= sck_o;
      gap_q <= (sck_o != sck_q) ? 9'h000 : gap_q + {8'h00, gap_q != 9'h1FE};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_data_rd;
    psel && penable && !pwrite && paddr == 8'h0C;
  endsequence
  sequence s_sck_move;
    sck_oe && sck_o != sck_q;
  endsequence
  map_err_a: assert property (acc |-> pslverr ==
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C})) else $error("bad slave error");
  nss_drive_a: assert property (nss_oe == (c1_q[2] && c0_q[2] && c0_q[6]))
    else $error("bad select drive");
  tx_dma_a: assert property (tx_dma_req |-> c1_q[1]) else $error("tx dma ungated");
  rx_dma_a: assert property (rx_dma_req |-> c1_q[0]) else $error("rx dma ungated");
  irq_gate_a: assert property (irq |-> c1_q[7:5] != 3'h0) else $error("irq ungated");
  irq_hold_a: assert property (irq && !acc |=> irq) else $error("irq dropped");
  data_upper_a: assert property (s_data_rd |-> prdata[31:16] == 16'h0000 &&
    (c0_q[11] || prdata[15:8] == 8'h00)) else $error("bad data width");
  sck_gap_a: assert property (s_sck_move |->
    gap_q + 9'h001 >= (9'h001 << c0_q[5:3])) else $error("serial clock too fast");
endmodule : sics_asserts
bind sics_top sics_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .sck_o(sck_o), .sck_oe(sck_oe), .nss_oe(nss_oe), .irq(irq),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
`default_nettype wire

// ==== test/sics_peer.sv ====
// Mode 0 peer device sending a counting byte each frame.
// Assumes select active low and a clock idling low.
`timescale 1ns/100ps
`default_nettype none
module sics_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] nxt = 8'hA5;
  logic [7:0] tx = 8'hA5;
  logic [7:0] sh = 8'h00;
  logic rel = 1'b0;
  int cnt = 0;
  // Capture on rise, shift on fall
  always @(posedge sck) begin
    if (!sel_n) begin
      sh = {sh[6:0], mosi};
      cnt++;
      got = sh;
    end
  end
  always @(negedge sck) begin
    if (!sel_n) begin
      tx = (cnt == 8) ? nxt + 8'h01 : tx << 1;
      nxt = (cnt == 8) ? nxt + 8'h01 : nxt;
      cnt = (cnt == 8) ? 0 : cnt;
    end
  end
  // A released line shows the inverse of its last bit
  always @(posedge sel_n) rel = ~tx[7];
  always @(negedge sel_n) begin
    cnt = 0;
    tx = nxt;
  end
  assign miso = sel_n ? rel : tx[7];
endmodule : sics_peer
`default_nettype wire

// ==== test/test_spi_i2s_control_status.sv ====
// Self-checking bench for the serial control block and a mode 0 peer.
// Assumes this module is the only APB master; pins resolve from enables.
`timescale 1ns/100ps
`default_nettype none
module test_spi_i2s_control_status;
  import sics_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, err, tb_sck, sel_n_pull, junk;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic nss_o, nss_oe, ws_o, ws_oe, irq, tx_dma_req, rx_dma_req, peer_miso;
  logic [7:0] got;
  int n_errors = 0;
  int checked = 0;
  // Undriven data line toggles so a stale level never looks valid
  wire logic sck_w = sck_oe ? sck_o : tb_sck;
  wire logic sel_n_w = nss_oe ? nss_o : sel_n_pull;
  wire logic mosi_w = mosi_oe ? mosi_o : junk;
  wire logic miso_w = miso_oe ? miso_o : peer_miso;
  sics_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe(miso_oe), .nss_i(sel_n_w), .nss_o(nss_o), .nss_oe(nss_oe), .ws_i(1'b0),
    .ws_o(ws_o), .ws_oe(ws_oe), .tx_checksum_i(16'h0000), .rx_checksum_i(16'h0000),
    .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  sics_peer peer_u (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n_w), .miso(peer_miso), .got(got));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      n_errors++;
      test_done();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic wait_st(input logic [7:0] m);
    r = 32'h0;
    for (int i = 0; i < 100 && (r[7:0] & m) == 8'h00; i++) rd(SICS_OFS_STATUS);
    if ((r[7:0] & m) == 8'h00) begin
      $display("BAD wait_st exp %h seen %h", m, r[7:0]);
      n_errors++;
      test_done();
    end
  endtask : wait_st
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4));
      chk("reset value", r, (i == 2) ? SICS_STAT_RESET : 32'h0);
    end
    // Audio select only moves while the port is off
    wr(SICS_OFS_AUDIO, 32'h800);
    wr(SICS_OFS_AUDIO, 32'hE00);
    @(negedge pclk);
    chk("word select", {ws_oe, ws_o}, 2'h3);
    wr(SICS_OFS_AUDIO, 32'h800);
    rd(SICS_OFS_AUDIO);
    chk("audio ctl", r, 32'h800);
    wr(SICS_OFS_AUDIO, 32'h0);
    rd(8'h10);
    chk("unmapped", {err, r[30:0]}, 32'h8000_0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_irq_dma();
    wr(SICS_OFS_CTL_IRQ, 32'hE7);
    rd(SICS_OFS_CTL_IRQ);
    chk("ctl_irq", r, 32'hE7);
    chk("irq dma on", {irq, tx_dma_req, rx_dma_req}, 3'h6);
    wr(SICS_OFS_CTL_IRQ, 32'h0);
    @(negedge pclk);
    chk("irq dma off", {irq, tx_dma_req, rx_dma_req}, 3'h0);
    $display("t_irq_dma done");
  endtask : t_irq_dma
  task automatic t_master();
    wr(SICS_OFS_CTL_IRQ, 32'h04);
    wr(SICS_OFS_CTL_MAIN, 32'h344);
    @(negedge pclk);
    chk("select out", {nss_oe, nss_o}, 2'h2);
    wr(SICS_OFS_DATA, 32'h1C3);
    rd(SICS_OFS_STATUS);
    chk("busy", {r[7], r[1:0]}, 3'h6);
    wait_st(8'h01);
    chk("idle", {r[7], r[1:0]}, 3'h3);
    chk("peer got", got, 8'hC3);
    chk("idle clock", sck_o, 1'b0);
    rd(SICS_OFS_DATA);
    chk("rx word", r, 32'hA5);
    rd(SICS_OFS_STATUS);
    chk("rf clear", r[0], 1'b0);
    $display("t_master done");
  endtask : t_master
  task automatic t_overrun();
    wr(SICS_OFS_CTL_IRQ, 32'h24);
    wr(SICS_OFS_DATA, 32'h11);
    wait_st(8'h01);
    wr(SICS_OFS_DATA, 32'h22);
    wait_st(8'h40);
    chk("overrun", {r[6], r[0]}, 2'h3);
    @(negedge pclk);
    chk("err irq", irq, 1'b1);
    rd(SICS_OFS_DATA);
    chk("old word", r, 32'hA6);
    rd(SICS_OFS_STATUS);
    chk("ovr held", r[6], 1'b1);
    rd(SICS_OFS_STATUS);
    chk("ovr clear", r[6], 1'b0);
    @(negedge pclk);
    chk("irq free", irq, 1'b0);
    $display("t_overrun done");
  endtask : t_overrun
  task automatic t_crc();
    wr(SICS_OFS_DATA, 32'h33);
    // Checksum-next set once the last data word is in
    wr(SICS_OFS_CTL_MAIN, 32'h3344);
    wait_st(8'h10);
    chk("crc set", {r[6], r[4]}, 2'h3);
    rd(SICS_OFS_CTL_MAIN);
    chk("crc next", r, 32'h2344);
    wr(SICS_OFS_STATUS, 32'h0);
    rd(SICS_OFS_STATUS);
    chk("crc clear", r[4], 1'b0);
    rd(SICS_OFS_DATA);
    chk("data kept", r, 32'hA8);
    $display("t_crc done");
  endtask : t_crc
  task automatic t_cfg();
    wr(SICS_OFS_CTL_MAIN, 32'h0);
    wr(SICS_OFS_CTL_IRQ, 32'h0);
    sel_n_pull <= 1'b0;
    wr(SICS_OFS_CTL_MAIN, 32'h44);
    rd(SICS_OFS_STATUS);
    chk("cfg set", r[5], 1'b1);
    sel_n_pull <= 1'b1;
    wr(SICS_OFS_CTL_MAIN, 32'h44);
    rd(SICS_OFS_STATUS);
    chk("cfg clear", r[5], 1'b0);
    $display("t_cfg done");
  endtask : t_cfg
  task automatic t_underrun();
    wr(SICS_OFS_CTL_MAIN, 32'h40);
    sel_n_pull <= 1'b0;
    repeat (4) begin
      @(posedge pclk);
      tb_sck <= ~tb_sck;
    end
    rd(SICS_OFS_STATUS);
    chk("urun set", r[3], 1'b1);
    rd(SICS_OFS_STATUS);
    chk("urun clear", r[3], 1'b0);
    wr(SICS_OFS_CTL_MAIN, 32'h0);
    sel_n_pull <= 1'b1;
    $display("t_underrun done");
  endtask : t_underrun
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) junk <= ~junk;
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tb_sck = 1'b0;
    sel_n_pull = 1'b1;
    junk = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_irq_dma();
    t_master();
    t_overrun();
    t_crc();
    t_cfg();
    t_underrun();
    test_done();
  end
endmodule : test_spi_i2s_control_status
`default_nettype wire
